// ---- src/bank_cmd_pkg.sv ----
// Package of command codes, bank states and timing counts for bank tracking
package bank_cmd_pkg;
  // Clock period in ns
  localparam int CLK_PERIOD_NS = 100;
  // Interval times in ns, converted to cycles rounding up; mode set and burst times given in cycles
  localparam int T_ROW_PRE_NS = 19;
  localparam int T_ROW_COL_NS = 19;
  localparam int T_ROW_CYC_NS = 67;
  localparam int T_MODE_CYC = 2;
  localparam int T_BURST_CYC = 4;
  localparam int RP_CYC = (T_ROW_PRE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RCD_CYC = (T_ROW_COL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_CYC = (T_ROW_CYC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Counter width
  localparam int CNT_W = 8;
  // Command encodings {cs_n, ras_n, cas_n, we_n} for the low-select cases
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_TERM = 4'h6;
  // Per-bank state, one-hot
  typedef enum logic [7:0] {
    BK_IDLE = 8'h01,
    BK_ACTIVATING = 8'h02,
    BK_ACTIVE = 8'h04,
    BK_READ = 8'h08,
    BK_WRITE = 8'h10,
    BK_PRECHARGING = 8'h20,
    BK_READ_AUTO = 8'h40,
    BK_WRITE_AUTO = 8'h80
  } bank_state_t;
  // Device-wide phase, one-hot
  typedef enum logic [3:0] {
    DEV_NORMAL = 4'h1,
    DEV_REFRESHING = 4'h2,
    DEV_MODE_ACCESS = 4'h4,
    DEV_PRE_ALL = 4'h8
  } dev_phase_t;
endpackage

// ---- src/sdram_bank_command_legality.sv ----
// Per-bank command decoder and state tracker for a synchronous DRAM
// Contract
// - Chip select high is a deselect; current operations continue.
// - Select low with all strobes high is a no-operation.
// - Activate in an idle bank opens a row.
// - Precharge to an idle bank acts as a no-operation.
// - Read command in an open-row bank starts a read burst.
// - Write command in an open-row bank starts a write burst.
// - Precharge in a row-active bank closes the row.
// - New read or write abandons a running plain burst.
// - Precharge during a plain burst truncates it and precharges.
// - Burst terminate stops the most recent burst in any bank if it is a plain burst.
// - Decoding only with clock enable high on prior and current edge.
// - Precharge enters precharging; idle after row precharge time.
// - Activate enters activating; row active after row-to-column delay.
// - Auto-close read or write ends idle after burst length plus row precharge time.
// - Refresh phase ends after row cycle time with all banks idle.
// - Mode set phase ends after mode set delay, all banks idle.
// - Precharge-all phase ends after row precharge time, all idle.
// - Read and write may carry auto-close either way, same legality.
`timescale 1ns/1ns
module sdram_bank_command_legality
  import bank_cmd_pkg::*;
#(
  parameter int BANKS = 4,
  parameter int BA_W = 2
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_cke,
  input wire logic i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic [BA_W-1:0] i_bank,
  input wire logic i_auto_close_option,
  input wire logic i_all_banks,
  output logic [BANKS*8-1:0] o_bank_state,
  output logic [3:0] o_dev_phase,
  output logic o_cmd_valid,
  output logic o_cmd_illegal
);

  // All state of the tracker in one record
  typedef struct packed {
    // Two-stage synchronisers for every pin
    logic [1:0] cke_sync;
    logic [1:0] cs_n_sync;
    logic [1:0] ras_n_sync;
    logic [1:0] cas_n_sync;
    logic [1:0] we_n_sync;
    logic [1:0][BA_W-1:0] bank_sync;
    logic [1:0] ap_sync;
    logic [1:0] all_sync;

    // Enable as seen on the previous decode edge
    logic prior_edge_clock_enable;

    // Per-bank state and interval counters
    bank_state_t [BANKS-1:0] bank_st;
    logic [BANKS-1:0][CNT_W-1:0] bank_cnt;

    // Device-wide phase and its counter
    dev_phase_t dev_ph;
    logic [CNT_W-1:0] dev_cnt;

    // Bank of the most recent burst, and whether it still runs
    logic [BA_W-1:0] last_burst_bank;
    logic burst_live;

    // Output registers
    logic [BANKS*8-1:0] out_state;
    logic [3:0] out_phase;
    logic out_valid;
    logic out_illegal;
  } state_t;

  // Current and next state
  state_t st_reg;
  state_t st_next;

  // Cycle count as a counter value, never below one cycle
  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = (n < 1) ? CNT_W'(1) : CNT_W'(n);
  endfunction

  // True when a bank sits in a plain burst
  function automatic logic in_burst(input bank_state_t s);
    in_burst = (s == BK_READ) || (s == BK_WRITE);
  endfunction

  // Command word from the synchronised strobe lines
  function automatic logic [3:0] cmd_word(input logic ras_n,
                                          input logic cas_n,
                                          input logic we_n);
    cmd_word = {1'b0, ras_n, cas_n, we_n};
  endfunction

  // Read or write, the two column commands
  function automatic logic is_col_cmd(input logic [3:0] c);
    is_col_cmd = (c == CMD_READ) || (c == CMD_WRITE);
  endfunction

  // Device-wide commands that need every bank idle
  function automatic logic is_dev_cmd(input logic [3:0] c);
    is_dev_cmd = (c == CMD_REF) || (c == CMD_MRS);
  endfunction

  // States whose interval must run out before the bank takes a command
  function automatic logic is_timed(input bank_state_t s);
    is_timed = (s == BK_ACTIVATING) || (s == BK_PRECHARGING) ||
               (s == BK_READ_AUTO) || (s == BK_WRITE_AUTO);
  endfunction

  // States that forbid a precharge of all banks
  function automatic logic blocks_pre_all(input bank_state_t s);
    blocks_pre_all = (s == BK_ACTIVATING) || (s == BK_READ_AUTO) ||
                     (s == BK_WRITE_AUTO);
  endfunction

  // State that a bank takes once its interval has run out
  function automatic bank_state_t timed_next(input bank_state_t s);
    case (s)
      BK_PRECHARGING: timed_next = BK_IDLE;
      BK_ACTIVATING: timed_next = BK_ACTIVE;
      BK_READ_AUTO: timed_next = BK_IDLE;
      BK_WRITE_AUTO: timed_next = BK_IDLE;
      default: timed_next = s;
    endcase
  endfunction

  // Burst state that a column command opens
  function automatic bank_state_t col_state(input logic [3:0] c,
                                            input logic close);
    if (close) begin
      col_state = (c == CMD_READ) ? BK_READ_AUTO : BK_WRITE_AUTO;
    end else begin
      col_state = (c == CMD_READ) ? BK_READ : BK_WRITE;
    end
  endfunction

  // Flatten the bank states into the output bus layout
  function automatic logic [BANKS*8-1:0] pack_states(
      input bank_state_t [BANKS-1:0] s);
    pack_states = '0;
    for (int i = 0; i < BANKS; i++) begin
      pack_states[i*8 +: 8] = s[i];
    end
  endfunction

  // Next-state logic for decoding and bank tracking; pins pass two
  // flops and one decode stage, so outputs trail the pins by three edges
  always_comb begin
    logic [3:0] cmd;
    logic current_edge_clock_enable;
    logic decode;
    logic all_idle;
    logic illegal;
    int b;
    b = 0;
    cmd = '0;
    current_edge_clock_enable = 1'b0;
    decode = 1'b0;
    all_idle = 1'b1;
    // Hold everything unless a rule below moves it
    st_next = st_reg;
    illegal = 1'b0;

    // Two-stage synchronisers for pin inputs
    st_next.cke_sync = {st_reg.cke_sync[0], i_cke};
    st_next.cs_n_sync = {st_reg.cs_n_sync[0], i_cs_n};
    st_next.ras_n_sync = {st_reg.ras_n_sync[0], i_ras_n};
    st_next.cas_n_sync = {st_reg.cas_n_sync[0], i_cas_n};
    st_next.we_n_sync = {st_reg.we_n_sync[0], i_we_n};
    st_next.bank_sync = {st_reg.bank_sync[0], i_bank};
    st_next.ap_sync = {st_reg.ap_sync[0], i_auto_close_option};
    st_next.all_sync = {st_reg.all_sync[0], i_all_banks};
    current_edge_clock_enable = st_reg.cke_sync[1];
    st_next.prior_edge_clock_enable = current_edge_clock_enable;

    // Decode only while enable held on both edges
    decode = st_reg.prior_edge_clock_enable &&
             current_edge_clock_enable;
    cmd = cmd_word(st_reg.ras_n_sync[1], st_reg.cas_n_sync[1],
                   st_reg.we_n_sync[1]);
    b = int'(st_reg.bank_sync[1]);

    // Interval counters and timed state changes per bank
    for (int i = 0; i < BANKS; i++) begin
      if (st_reg.bank_cnt[i] != '0) begin
        st_next.bank_cnt[i] = st_reg.bank_cnt[i] - CNT_W'(1);
      end
      if (st_reg.bank_cnt[i] == CNT_W'(1)) begin
        st_next.bank_st[i] = timed_next(st_reg.bank_st[i]);
      end
    end

    // Whole-device idle test for refresh and mode set
    all_idle = 1'b1;
    for (int i = 0; i < BANKS; i++) begin
      if (st_reg.bank_st[i] != BK_IDLE) begin
        all_idle = 1'b0;
      end
    end
    // Device-wide phase timer
    if (st_reg.dev_cnt != '0) begin
      st_next.dev_cnt = st_reg.dev_cnt - CNT_W'(1);
    end
    // Phase end forces every bank idle, whatever it held before
    if (st_reg.dev_ph != DEV_NORMAL && st_reg.dev_cnt == CNT_W'(1)) begin
      st_next.dev_ph = DEV_NORMAL;
      for (int i = 0; i < BANKS; i++) begin
        st_next.bank_st[i] = BK_IDLE;
        st_next.bank_cnt[i] = '0;
      end
    end

    // Command decode; select high is a deselect
    if (decode && !st_reg.cs_n_sync[1]) begin
      if (cmd == CMD_NOP) begin
        illegal = 1'b0;
      end else if (st_reg.dev_ph != DEV_NORMAL) begin
        illegal = 1'b1;
      end else if (is_dev_cmd(cmd)) begin
        if (!all_idle || st_reg.burst_live) begin
          illegal = 1'b1;
        end else if (cmd == CMD_REF) begin
          st_next.dev_ph = DEV_REFRESHING;
          st_next.dev_cnt = cyc(RC_CYC);
        end else begin
          st_next.dev_ph = DEV_MODE_ACCESS;
          st_next.dev_cnt = cyc(T_MODE_CYC);
        end
      end else if (cmd == CMD_PRE && st_reg.all_sync[1]) begin
        // Precharge of all banks checks each one
        for (int i = 0; i < BANKS; i++) begin
          if (blocks_pre_all(st_reg.bank_st[i])) begin
            illegal = 1'b1;
          end
        end
        if (!illegal) begin
          st_next.dev_ph = DEV_PRE_ALL;
          st_next.dev_cnt = cyc(RP_CYC);
          st_next.burst_live = 1'b0;
        end
      end else if (cmd == CMD_TERM) begin
        // Stops the latest burst wherever it lives, if it is a plain burst
        // With no live burst this acts as a no-operation
        if (st_reg.burst_live &&
            in_burst(st_reg.bank_st[st_reg.last_burst_bank])) begin
          st_next.bank_st[st_reg.last_burst_bank] = BK_ACTIVE;
        end
        st_next.burst_live = 1'b0;
      end else if (is_timed(st_reg.bank_st[b])) begin
        // Bank busy with a timed interval
        illegal = 1'b1;
      end else begin
        case (st_reg.bank_st[b])
          BK_IDLE: begin
            if (cmd == CMD_ACT) begin
              st_next.bank_st[b] = BK_ACTIVATING;
              st_next.bank_cnt[b] = cyc(RCD_CYC);
            end else if (cmd != CMD_PRE) begin
              illegal = 1'b1;
            end
          end
          BK_ACTIVE, BK_READ, BK_WRITE: begin
            if (is_col_cmd(cmd)) begin
              // New burst replaces any running one
              st_next.last_burst_bank = BA_W'(b);
              st_next.burst_live = 1'b1;
              st_next.bank_st[b] =
                col_state(cmd, st_reg.ap_sync[1]);
              if (st_reg.ap_sync[1]) begin
                st_next.bank_cnt[b] = cyc(T_BURST_CYC + RP_CYC);
              end
            end else if (cmd == CMD_PRE) begin
              st_next.bank_st[b] = BK_PRECHARGING;
              st_next.bank_cnt[b] = cyc(RP_CYC);
              if (st_reg.last_burst_bank == BA_W'(b)) begin
                st_next.burst_live = 1'b0;
              end
            end else begin
              illegal = 1'b1;
            end
          end
          default: illegal = 1'b1;
        endcase
      end
    end

    // Registered outputs
    st_next.out_state = pack_states(st_next.bank_st);
    st_next.out_phase = st_next.dev_ph;
    // Pulses for an accepted or a refused command
    st_next.out_valid = decode && !st_reg.cs_n_sync[1] && !illegal;
    st_next.out_illegal = decode && !st_reg.cs_n_sync[1] && illegal;
  end

  // State register with synchronous reset
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_reg <= '0;
      // Strobe synchronisers start at the deselected level
      st_reg.cs_n_sync <= 2'h3;
      st_reg.ras_n_sync <= 2'h3;
      st_reg.cas_n_sync <= 2'h3;
      st_reg.we_n_sync <= 2'h3;

      // Every bank idle, device in its normal phase
      for (int i = 0; i < BANKS; i++) begin
        st_reg.bank_st[i] <= BK_IDLE;
        st_reg.out_state[i*8 +: 8] <= BK_IDLE;
      end
      st_reg.dev_ph <= DEV_NORMAL;
      st_reg.out_phase <= DEV_NORMAL;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign o_bank_state = st_reg.out_state;
  assign o_dev_phase = st_reg.out_phase;
  assign o_cmd_valid = st_reg.out_valid;
  assign o_cmd_illegal = st_reg.out_illegal;

endmodule // sdram_bank_command_legality

// ---- tb/bank_cmd_sva.sv ----
// Port checker for the bank command tracker
`timescale 1ns/1ns
module bank_cmd_sva
  import bank_cmd_pkg::*;
#(
  parameter int BANKS = 4,
  parameter int BA_W = 2
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_cke,
  input wire logic i_cs_n,
  input wire logic i_ras_n,
  input wire logic i_cas_n,
  input wire logic i_we_n,
  input wire logic [BA_W-1:0] i_bank,
  input wire logic i_auto_close_option,
  input wire logic i_all_banks,
  input wire logic [BANKS*8-1:0] o_bank_state,
  input wire logic [3:0] o_dev_phase,
  input wire logic o_cmd_valid,
  input wire logic o_cmd_illegal
);
  localparam int PW = BA_W + 6;
  logic [PW-1:0] p1_reg, p2_reg, p3_reg;
  logic ck4_reg;
  logic [2:0] age_reg;
  logic live;
  logic [3:0] cmd3;
  logic [7:0] tgt;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // Pin history lined up with the output edge, plus age since reset
  always_ff @(posedge i_clk) begin
    p1_reg <= {i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_bank,
               i_auto_close_option};
    p2_reg <= p1_reg;
    p3_reg <= p2_reg;
    ck4_reg <= p3_reg[PW-1];
    if (i_sys_rst) age_reg <= 3'h0;
    else if (age_reg != 3'h4) age_reg <= age_reg + 3'h1;
  end
  // Decoded command and the state byte of its bank
  assign live = (age_reg == 3'h4) && p3_reg[PW-1] && ck4_reg
                && !p3_reg[PW-2];
  assign cmd3 = p3_reg[PW-2 -: 4];
  assign tgt = o_bank_state[p3_reg[BA_W:1]*8 +: 8];
  desel_quiet_a: assert property (p3_reg[PW-2] |->
    !o_cmd_valid && !o_cmd_illegal) else $error("pulse after deselect");
  cke_quiet_a: assert property (!p3_reg[PW-1] |->
    !o_cmd_valid && !o_cmd_illegal) else $error("pulse with enable low");
  nop_pass_a: assert property (live && cmd3 == CMD_NOP |->
    o_cmd_valid && !o_cmd_illegal) else $error("no-op not accepted");
  act_open_a: assert property (live && o_cmd_valid && cmd3 == CMD_ACT
    |-> tgt == 8'h02) else $error("activate did not open row");
  rd_burst_a: assert property (live && o_cmd_valid
    && cmd3 == CMD_READ
    |-> tgt == (p3_reg[0] ? 8'h40 : 8'h08)) else $error("read state wrong");
  ref_phase_a: assert property (live && o_cmd_valid && cmd3 == CMD_REF
    |-> o_dev_phase == 4'h2 ##1 o_dev_phase == 4'h1)
    else $error("refresh phase wrong");
  mrs_phase_a: assert property (live && o_cmd_valid && cmd3 == CMD_MRS
    |-> (o_dev_phase == 4'h4)[*2] ##1 o_dev_phase == 4'h1)
    else $error("mode access phase wrong");
  rcd_step_a: assert property (o_bank_state[7:0] == 8'h02 |=>
    o_bank_state[7:0] == 8'h04) else $error("activating did not end");
  pre_step_a: assert property (o_bank_state[7:0] == 8'h20 |=>
    o_bank_state[7:0] == 8'h01) else $error("precharge did not end");
endmodule // bank_cmd_sva

bind sdram_bank_command_legality bank_cmd_sva #(.BANKS(BANKS), .BA_W(BA_W))
  u_sva (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cke(i_cke),
  .i_cs_n(i_cs_n), .i_ras_n(i_ras_n), .i_cas_n(i_cas_n), .i_we_n(i_we_n),
  .i_bank(i_bank), .i_auto_close_option(i_auto_close_option),
  .i_all_banks(i_all_banks), .o_bank_state(o_bank_state),
  .o_dev_phase(o_dev_phase), .o_cmd_valid(o_cmd_valid),
  .o_cmd_illegal(o_cmd_illegal));

// ---- tb/sdram_ctrl_model.sv ----
// Memory controller model that drives the command pins
`timescale 1ns/1ns
module sdram_ctrl_model (
  input wire logic i_clk,
  output logic o_cke,
  output logic o_cs_n,
  output logic o_ras_n,
  output logic o_cas_n,
  output logic o_we_n,
  output logic [1:0] o_bank,
  output logic o_ap,
  output logic o_all
);
  // Pins start deselected
  initial begin
    o_cke = 1'b1;
    o_cs_n = 1'b1;
    {o_ras_n, o_cas_n, o_we_n, o_bank, o_ap, o_all} = 7'h00;
  end
  // One command, launched at a falling edge
  task automatic send(input logic [3:0] c, input logic [1:0] b,
                      input logic a, input logic al, input logic ck);
    @(negedge i_clk);
    o_cke = ck;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = c;
    {o_bank, o_ap, o_all} = {b, a, al};
  endtask
  // Gap cycles: deselect, released lines flip every cycle
  task automatic rest(input int n);
    repeat (n) begin
      @(negedge i_clk);
      o_cke = 1'b1;
      o_cs_n = 1'b1;
      {o_ras_n, o_cas_n, o_we_n, o_bank, o_ap, o_all} =
        ~{o_ras_n, o_cas_n, o_we_n, o_bank, o_ap, o_all};
    end
  endtask
endmodule // sdram_ctrl_model

// ---- tb/sdram_bank_command_legality_tb_top.sv ----
// Self-checking bench for the bank command tracker
`timescale 1ns/1ns
module sdram_bank_command_legality_tb_top import bank_cmd_pkg::*;;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic cke, cs_n, ras_n, cas_n, we_n, ap, al, vld, ill;
  logic [1:0] bank, b, b2;
  logic [31:0] bs;
  logic [3:0] ph;
  logic [14:0] e;
  logic [14:0] expq[$];
  int err_count = 0;
  int checked = 0;
  always #50 i_clk = ~i_clk;
  sdram_ctrl_model u_ctrl (.i_clk(i_clk), .o_cke(cke), .o_cs_n(cs_n),
    .o_ras_n(ras_n), .o_cas_n(cas_n), .o_we_n(we_n), .o_bank(bank),
    .o_ap(ap), .o_all(al));
  sdram_bank_command_legality u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_cke(cke), .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n),
    .i_we_n(we_n), .i_bank(bank), .i_auto_close_option(ap),
    .i_all_banks(al), .o_bank_state(bs), .o_dev_phase(ph),
    .o_cmd_valid(vld), .o_cmd_illegal(ill));
  // Compare and count
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    checked++;
    if (g !== x) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // Verdict and end of run
  task automatic tally_and_finish;
    $display("errors %0d of %0d checks", err_count, checked);
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Issue a command, note the expected pulse, then leave a gap
  task automatic run(input logic [3:0] c, input logic [1:0] bk,
    input logic a, input logic l, input logic ck, input logic il,
    input logic [7:0] st, input logic [3:0] p, input int n);
    u_ctrl.send(c, bk, a, l, ck);
    if (ck && !c[3]) expq.push_back({bk, il, st, p});
    u_ctrl.rest(n);
  endtask
  // Each pulse is matched against the oldest note
  always @(negedge i_clk) begin
    if (vld === 1'b1 || ill === 1'b1) begin
      e = (expq.size() != 0) ? expq.pop_front() : 15'h7fff;
      cmp(32'({ill, vld, bs[e[14:13]*8 +: 8], ph}),
          32'({e[12], ~e[12], e[11:0]}));
    end
  end
  // Hang guard
  initial begin
    #300000;
    err_count++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    b = 2'($urandom(89));
    b2 = b ^ 2'h1;
    repeat (6) @(negedge i_clk);
    i_sys_rst = 1'b0;
    u_ctrl.rest(4);
    run(CMD_NOP, b, 0, 0, 1, 0, 8'h01, 4'h1, 4);
    run({1'b1, 3'($urandom)}, b, 0, 0, 1, 0, 8'h00, 4'h0, 4);
    run(CMD_ACT, b, 0, 0, 0, 0, 8'h00, 4'h0, 4);
    run(CMD_PRE, b, 0, 0, 1, 0, 8'h01, 4'h1, 4);
    run(CMD_REF, b, 0, 0, 1, 0, 8'h01, 4'h2, 4);
    run(CMD_MRS, b, 0, 0, 1, 0, 8'h01, 4'h4, 5);
    run(CMD_ACT, b, 0, 0, 1, 0, 8'h02, 4'h1, 0);
    run(CMD_READ, b, 0, 0, 1, 1, 8'h04, 4'h1, 4);
    run(CMD_ACT, b, 0, 0, 1, 1, 8'h04, 4'h1, 2);
    run(CMD_REF, b, 0, 0, 1, 1, 8'h04, 4'h1, 2);
    run(CMD_READ, b, 0, 0, 1, 0, 8'h08, 4'h1, 0);
    run(CMD_READ, b, 0, 0, 1, 0, 8'h08, 4'h1, 0);
    run(CMD_WRITE, b, 0, 0, 1, 0, 8'h10, 4'h1, 0);
    run(CMD_TERM, b, 0, 0, 1, 0, 8'h04, 4'h1, 2);
    run(CMD_WRITE, b, 0, 0, 1, 0, 8'h10, 4'h1, 0);
    run(CMD_PRE, b, 0, 0, 1, 0, 8'h20, 4'h1, 3);
    run(CMD_ACT, 2'h0, 0, 0, 1, 0, 8'h02, 4'h1, 3);
    run(CMD_PRE, 2'h0, 0, 0, 1, 0, 8'h20, 4'h1, 3);
    run(CMD_ACT, b, 0, 0, 1, 0, 8'h02, 4'h1, 3);
    run(CMD_WRITE, b, 1, 0, 1, 0, 8'h80, 4'h1, 0);
    run(CMD_PRE, b, 0, 0, 1, 1, 8'h80, 4'h1, 8);
    run(CMD_ACT, b, 0, 0, 1, 0, 8'h02, 4'h1, 3);
    run(CMD_READ, b, 1, 0, 1, 0, 8'h40, 4'h1, 8);
    run(CMD_ACT, b, 0, 0, 1, 0, 8'h02, 4'h1, 3);
    run(CMD_PRE, b2, 0, 1, 1, 0, 8'h01, 4'h8, 4);
    cmp(bs, {4{8'h01}});
    u_ctrl.rest(6);
    cmp(expq.size(), 0);
    tally_and_finish();
  end
endmodule // sdram_bank_command_legality_tb_top
